// [verilog/sib_serial_channel.sv]
// Clocked serial channel: AHB-Lite registers, baud generator,
// transfer engine and the idle levels of the serial pins.
// Assumes one AHB-Lite master; serial pins are async to mclk.
`timescale 1ns/1ps
`default_nettype none
module sib_serial_channel (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sckIn,
  input wire logic sdiIn,
  output sib_pkg::sib_pins_t pins,
  output logic rxCompleteIrq
);
  import sib_pkg::*;
  sib_state_t st_q;
  sib_state_t st_d;
  logic extClk, preTick, baudTick, tick, accept, wrEn;
  logic wrTx, rdRx, startTx, startRx, sampleEdge, finish;
  logic [7:0] wdat, word;
  logic [4:0] lastHalf, preDiv;
  logic [3:0] lenBits, preMax;
  // Serial bit picked by bit order
  function automatic logic outBit(input logic lsbFirst,
                                  input logic [7:0] w);
    outBit = lsbFirst ? w[0] : w[7];
  endfunction
  // One shift step, new bit enters at the far end
  function automatic logic [7:0] shiftIn(input logic lsbFirst,
                                         input logic [7:0] w,
                                         input logic b);
    shiftIn = lsbFirst ? {b, w[7:1]} : {w[6:0], b};
  endfunction

  // --------------------------------------------------------------
  // Baud generator decode
  // --------------------------------------------------------------
  // Prescale by 2^(k+1), then count N = compare (0 means 256)
  always_comb begin
    preDiv = PRE_BASE << st_q.prsMode[PRSM_K_MSB:0];
    preMax = 4'(preDiv - 5'h01);
    extClk = st_q.cfg.cks == CKS_EXT;
    preTick = st_q.cfg.pwr && st_q.preCnt == preMax;
    // Compare minus one wraps 00 to FF, giving 256 counts
    baudTick = preTick && st_q.cmpCnt == 8'(st_q.prsCmp - 8'h01);
    // External clock: every synchronised edge is a half period
    tick = extClk ? (st_q.sckSync[1] ^ st_q.sckPrev) : baudTick;
    if (st_q.cfg.cl == 4'h0 || st_q.cfg.cl > LEN_MAX) begin
      lenBits = LEN_MAX;
    end else begin
      lenBits = st_q.cfg.cl;
    end
    lastHalf = 5'({lenBits, 1'b0} - 5'h01);
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  // Bus writes come first so that engine events override them
  always_comb begin
    st_d = st_q;
    st_d.rxIrq = 1'b0;
    startTx = 1'b0;
    startRx = 1'b0;
    sampleEdge = 1'b0;
    finish = 1'b0;
    word = st_q.shReg;
    // Two-flop synchronisers for the pin inputs
    st_d.sckSync = {st_q.sckSync[0], sckIn};
    st_d.sdiSync = {st_q.sdiSync[0], sdiIn};
    st_d.sckPrev = st_q.sckSync[1];
    // AHB address phase; reads get one wait state
    accept = hsel && hready && htrans[1];
    st_d.dWrite = accept && hwrite && hsize == SIZE_WORD;
    st_d.rdWait = accept && !hwrite;
    if (accept) begin
      st_d.addr = {haddr[7:2], 2'b00};
    end
    wrEn = st_q.dWrite;
    wdat = hwdata[7:0];
    wrTx = wrEn && st_q.addr == OFS_TXB;
    rdRx = st_q.rdWait && st_q.addr == OFS_RXB;
    // Read data captured in the wait cycle; unmapped reads zero
    if (st_q.rdWait) begin
      case (st_q.addr)
        OFS_CTL0: st_d.hrdata = {27'h0, st_q.cfg.tms, st_q.cfg.dir,
                                 st_q.cfg.rxe, st_q.cfg.txe,
                                 st_q.cfg.pwr};
        OFS_CTL1: st_d.hrdata = {27'h0, st_q.cfg.cks, st_q.cfg.dap,
                                 st_q.cfg.ckp};
        OFS_CTL2: st_d.hrdata = {28'h0, st_q.cfg.cl};
        OFS_STAT: st_d.hrdata = {29'h0, st_q.rxFull, st_q.ove,
                                 st_q.busy};
        OFS_TXB: st_d.hrdata = {24'h0, st_q.txBuf};
        OFS_RXB: st_d.hrdata = {24'h0, st_q.rxBuf};
        OFS_PRSM: st_d.hrdata = {24'h0, st_q.prsMode};
        OFS_PRSCM: st_d.hrdata = {24'h0, st_q.prsCmp};
        default: st_d.hrdata = 32'h0000_0000;
      endcase
    end
    // Register writes; settings are not locked while powered
    if (wrEn) begin
      case (st_q.addr)
        OFS_CTL0: begin
          st_d.cfg.pwr = wdat[CTL0_PWR];
          st_d.cfg.txe = wdat[CTL0_TXE];
          st_d.cfg.rxe = wdat[CTL0_RXE];
          st_d.cfg.dir = wdat[CTL0_DIR];
          st_d.cfg.tms = wdat[CTL0_TMS];
        end
        OFS_CTL1: begin
          st_d.cfg.ckp = wdat[CTL1_CKP];
          st_d.cfg.dap = wdat[CTL1_DAP];
          st_d.cfg.cks = wdat[CTL1_CKS_MSB:CTL1_CKS_LSB];
        end
        OFS_CTL2: st_d.cfg.cl = wdat[CTL2_CL_MSB:0];
        OFS_STAT: begin
          if (wdat[STAT_OVE]) begin
            st_d.ove = 1'b0;
          end
        end
        OFS_PRSM: st_d.prsMode = wdat;
        OFS_PRSCM: st_d.prsCmp = wdat;
        default: begin
        end
      endcase
    end
    // Baud counters run only while powered
    if (!st_q.cfg.pwr) begin
      st_d.preCnt = 4'h0;
      st_d.cmpCnt = 8'h00;
    end else if (preTick) begin
      st_d.preCnt = 4'h0;
      st_d.cmpCnt = baudTick ? 8'h00 : 8'(st_q.cmpCnt + 8'h01);
    end else begin
      st_d.preCnt = 4'(st_q.preCnt + 4'h1);
    end
    // Transmit buffer write: single mode drops it while busy
    if (wrTx) begin
      if (!st_q.busy) begin
        st_d.txBuf = wdat;
        startTx = st_q.cfg.pwr && st_q.cfg.txe;
      end else if (st_q.cfg.tms) begin
        st_d.txBuf = wdat;
        st_d.txPend = 1'b1;
      end
      // Busy in single mode: write and start both ignored
    end
    // Receive read frees the buffer; rx-only starts only when idle
    if (rdRx) begin
      st_d.rxFull = 1'b0;
      if (!st_q.busy && st_q.cfg.pwr && !st_q.cfg.txe &&
          st_q.cfg.rxe) begin
        startRx = 1'b1;
      end
    end
    // Transfer engine: one tick is half a serial clock period
    if (startTx || startRx) begin
      st_d.shReg = startTx ? wdat : 8'h00;
      st_d.busy = 1'b1;
      st_d.tail = 1'b0;
      st_d.half = 5'h00;
      st_d.sckLvl = !st_q.cfg.ckp;
    end else if (st_q.busy && !st_q.tail && tick) begin
      // Phase 0 samples on even edges, phase 1 on odd edges
      sampleEdge = st_q.cfg.dap ? st_q.half[0] : !st_q.half[0];
      if (sampleEdge) begin
        st_d.sdiBit = st_q.sdiSync[1];
      end
      st_d.half = 5'(st_q.half + 5'h01);
      st_d.sckLvl = !st_q.sckLvl;
      if (st_q.half == lastHalf) begin
        // Phase 1 ends on a sample edge, so take the live bit
        word = st_q.cfg.dap ?
               shiftIn(st_q.cfg.dir, st_q.shReg, st_q.sdiSync[1]) :
               shiftIn(st_q.cfg.dir, st_q.shReg, st_q.sdiBit);
        st_d.rxIrq = 1'b1;
        if (st_q.cfg.rxe) begin
          st_d.rxBuf = word;
          // Unread word overwritten: overrun, set beats clear
          if (st_q.rxFull && !rdRx) begin
            st_d.ove = 1'b1;
          end
          st_d.rxFull = 1'b1;
        end
        // Phase 1 holds busy for one more half period
        if (st_q.cfg.dap) begin
          st_d.tail = 1'b1;
        end else begin
          finish = 1'b1;
        end
      end else if (!sampleEdge &&
                   !(st_q.cfg.dap && st_q.half == 5'h00)) begin
        st_d.shReg = shiftIn(st_q.cfg.dir, st_q.shReg, st_q.sdiBit);
      end
    end else if (st_q.busy && st_q.tail && baudTick) begin
      finish = 1'b1;
    end
    // End of frame: continuous mode chains a pending word
    if (finish) begin
      st_d.tail = 1'b0;
      if (st_q.cfg.tms && st_d.txPend) begin
        st_d.shReg = st_d.txBuf;
        st_d.txPend = 1'b0;
        st_d.half = 5'h00;
        st_d.sckLvl = !st_q.cfg.ckp;
      end else begin
        st_d.busy = 1'b0;
      end
    end
    // Power off aborts any frame
    if (!st_d.cfg.pwr) begin
      st_d.busy = 1'b0;
      st_d.tail = 1'b0;
      st_d.txPend = 1'b0;
      st_d.half = 5'h00;
    end
    // Pin levels from the next settings, so a rewrite shows at once
    st_d.pins.sckOeN = st_d.cfg.cks == CKS_EXT;
    if (st_d.cfg.pwr && st_d.busy) begin
      st_d.pins.sckOut = st_d.sckLvl;
      st_d.pins.sdoOut = st_d.cfg.txe &&
                         outBit(st_d.cfg.dir, st_d.shReg);
    end else begin
      st_d.pins.sckOut = !st_d.cfg.ckp;
      // Phase 1 presents the first bit ahead of the clock
      st_d.pins.sdoOut = st_d.cfg.txe && st_d.cfg.dap &&
                         outBit(st_d.cfg.dir, st_d.txBuf);
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Reset leaves the clock pin driven high, matching idle polarity 0
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.pins.sckOut <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Bus answers and outputs
  assign hreadyout = !st_q.rdWait;
  assign hrdata = st_q.hrdata;
  assign hresp = 1'b0;
  assign pins = st_q.pins;
  assign rxCompleteIrq = st_q.rxIrq;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  logic [12:0] gapCnt, expGap;
  logic gapOk;
  logic [8:0] nDiv;

  // Divisor expected from the current prescaler settings
  always_comb begin
    nDiv = (st_q.prsCmp == REG_RST) ? NDIV_ZERO : {1'b0, st_q.prsCmp};
    expGap = 13'({8'h00, PRE_BASE} << st_q.prsMode[PRSM_K_MSB:0]) *
             13'(nDiv);
  end

  // Cycles between baud ticks; restarts on any prescaler rewrite
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gapCnt <= 13'h0000;
      gapOk <= 1'b0;
    end else if (!st_q.cfg.pwr || (st_q.dWrite &&
               (st_q.addr == OFS_PRSM || st_q.addr == OFS_PRSCM))) begin
      gapCnt <= 13'h0000;
      gapOk <= 1'b0;
    end else if (baudTick) begin
      gapCnt <= 13'h0001;
      gapOk <= 1'b1;
    end else begin
      gapCnt <= 13'(gapCnt + 13'h0001);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_idle_hiz;
    !st_q.cfg.pwr && st_q.cfg.cks == CKS_EXT |-> pins.sckOeN;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("clock pin driven while external and off");
  property p_idle_sck;
    !st_q.cfg.pwr && st_q.cfg.cks != CKS_EXT &&
      $changed(st_q.cfg.ckp) |->
      !pins.sckOeN && pins.sckOut == !st_q.cfg.ckp;
  endproperty
  a_idle_sck: assert property (p_idle_sck)
    else $error("clock idle level missed a polarity rewrite");
  property p_idle_sdo_low;
    !st_q.cfg.pwr && (!st_q.cfg.txe || !st_q.cfg.dap) |->
      !pins.sdoOut;
  endproperty
  a_idle_sdo_low: assert property (p_idle_sdo_low)
    else $error("data out not low while off");
  property p_idle_sdo_bit;
    !st_q.cfg.pwr && st_q.cfg.txe && st_q.cfg.dap |->
      pins.sdoOut == (st_q.cfg.dir ? st_q.txBuf[0] : st_q.txBuf[7]);
  endproperty
  a_idle_sdo_bit: assert property (p_idle_sdo_bit)
    else $error("data out does not show the first bit");
  property p_baud_period;
    baudTick && gapOk |-> gapCnt == expGap;
  endproperty
  a_baud_period: assert property (p_baud_period)
    else $error("baud tick spacing wrong");
  property p_baud_zero;
    baudTick && gapOk && st_q.prsCmp == REG_RST |->
      (gapCnt >> ({1'b0, st_q.prsMode[PRSM_K_MSB:0]} + 3'h1)) ==
      13'(NDIV_ZERO);
  endproperty
  a_baud_zero: assert property (p_baud_zero)
    else $error("compare zero does not divide by 256");
  property p_busy_tail;
    $fell(st_q.busy) && st_q.cfg.pwr && st_q.cfg.dap |->
      $past(st_q.tail) && $past(baudTick);
  endproperty
  a_busy_tail: assert property (p_busy_tail)
    else $error("busy cleared without the half period");
  property p_tx_drop;
    wrTx && st_q.busy && !st_q.cfg.tms |=>
      st_q.txBuf == $past(st_q.txBuf) && !st_q.txPend;
  endproperty
  a_tx_drop: assert property (p_tx_drop)
    else $error("transmit write taken while busy");
  property p_rx_hold;
    rdRx && st_q.busy && !st_q.tail && !st_q.cfg.txe &&
      st_q.cfg.pwr |=> st_q.half >= $past(st_q.half);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive read restarted a busy frame");
endmodule // sib_serial_channel
`default_nettype wire

// [verilog/sib_pkg.sv]
// Constants and types of the serial channel block.
// Assumes one AHB-Lite master and a 200 MHz main clock.
package sib_pkg;
  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_CTL2 = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_TXB = 8'h10;
  localparam logic [7:0] OFS_RXB = 8'h14;
  localparam logic [7:0] OFS_PRSM = 8'h18;
  localparam logic [7:0] OFS_PRSCM = 8'h1C;
  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int CTL0_PWR = 0;
  localparam int CTL0_TXE = 1;
  localparam int CTL0_RXE = 2;
  localparam int CTL0_DIR = 3;
  localparam int CTL0_TMS = 4;
  localparam int CTL1_CKP = 0;
  localparam int CTL1_DAP = 1;
  localparam int CTL1_CKS_LSB = 2;
  localparam int CTL1_CKS_MSB = 4;
  localparam int CTL2_CL_MSB = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_OVE = 1;
  localparam int STAT_RXF = 2;
  localparam int PRSM_K_MSB = 1;
  // --------------------------------------------------------------
  // Codes, reset values and timing
  // --------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [2:0] CKS_EXT = 3'h7;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [3:0] LEN_MAX = 4'h8;
  localparam logic [4:0] PRE_BASE = 5'h02;
  localparam logic [8:0] NDIV_ZERO = 9'h100;
  localparam int CLK_MHZ = 200;
  localparam int BAUD_MAX_MHZ = 8;
  localparam int BAUD_MIN_DIV = (CLK_MHZ + BAUD_MAX_MHZ - 1) / BAUD_MAX_MHZ;
  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef struct packed {
    logic sckOut;
    logic sckOeN;
    logic sdoOut;
  } sib_pins_t;
  typedef struct packed {
    logic pwr;
    logic txe;
    logic rxe;
    logic dir;
    logic tms;
    logic ckp;
    logic dap;
    logic [2:0] cks;
    logic [3:0] cl;
  } sib_cfg_t;
  typedef struct packed {
    sib_cfg_t cfg;
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic [7:0] shReg;
    logic [7:0] prsMode;
    logic [7:0] prsCmp;
    logic [3:0] preCnt;
    logic [7:0] cmpCnt;
    logic busy;
    logic ove;
    logic rxFull;
    logic txPend;
    logic tail;
    logic sdiBit;
    logic sckLvl;
    logic rxIrq;
    logic [4:0] half;
    sib_pins_t pins;
    logic [7:0] addr;
    logic dWrite;
    logic rdWait;
    logic [31:0] hrdata;
    logic [1:0] sckSync;
    logic [1:0] sdiSync;
    logic sckPrev;
  } sib_state_t;
endpackage

// [dv/sib_peer_model.sv]
// Behavioural serial peer on the far side of the channel.
// Assumes the bench says when a frame is on and when to clock.
`timescale 1ns/1ps
`default_nettype none
module sib_peer_model (
  input wire logic mclk,
  input wire logic idleLvl,
  input wire logic go,
  input wire logic active,
  input wire logic fill,
  output logic sckIn,
  output logic sdiIn
);
  int edges = 0;
  int div = 0;
  initial sckIn = 1'b1;
  initial sdiIn = 1'b0;
  // ---------------------------------------------------------------
  // Clock and data
  // ---------------------------------------------------------------
  // Clock stands at its idle level outside a burst of 16 edges;
  // a released data line toggles so a stale level never passes
  always @(posedge mclk) begin
    if (edges == 0 && go) begin
      edges <= 16;
      div <= 0;
    end else if (edges != 0) begin
      if (div == 9) begin
        div <= 0;
        sckIn <= ~sckIn;
        edges <= edges - 1;
      end else begin
        div <= div + 1;
      end
    end else begin
      sckIn <= idleLvl;
    end
    sdiIn <= active ? fill : ~sdiIn;
  end
endmodule // sib_peer_model
`default_nettype wire

// [dv/serial_idle_pins_and_baud_generator_test.sv]
// Self-checking bench of the serial channel over AHB-Lite.
// Assumes the peer model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module serial_idle_pins_and_baud_generator_test;
  import sib_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic sckIn;
  logic sdiIn;
  logic rxCompleteIrq;
  sib_pins_t pins;
  logic peerGo = 1'b0;
  logic peerOn = 1'b0;
  int fails = 0;
  int checkCount = 0;
  int irqs = 0;
  logic [31:0] rdv;
  always #2.5 mclk = ~mclk;
  sib_serial_channel DUT (.mclk(mclk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .sckIn(sckIn), .sdiIn(sdiIn),
    .pins(pins), .rxCompleteIrq(rxCompleteIrq));
  sib_peer_model peer (.mclk(mclk), .idleLvl(1'b1), .go(peerGo),
    .active(peerOn), .fill(1'b1), .sckIn(sckIn), .sdiIn(sdiIn));
  // Pulses are counted mid-cycle, away from the launching edge
  always @(negedge mclk) if (rxCompleteIrq === 1'b1) irqs++;
  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Called just after a rising edge; hready is read mid-cycle
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic r;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= SIZE_WORD;
    do begin
      @(negedge mclk) r = hreadyout;
      @(posedge mclk);
    end while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge mclk) r = hreadyout;
      rd = hrdata;
      @(posedge mclk);
    end while (r !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    ahb(1'b1, a, {24'h0, d}, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask
  task automatic wait_irq(input int n);
    int i;
    for (i = 0; i < 20000 && irqs < n; i++) @(negedge mclk);
    chk("irq count", irqs, n);
    @(posedge mclk);
  endtask
  // Configuration only changes with the channel powered down
  task automatic cfg(input logic [7:0] k, input logic [7:0] n,
                     input logic [7:0] c1, input logic [7:0] c0);
    wr(OFS_CTL0, 8'h00);
    wr(OFS_PRSM, k);
    wr(OFS_PRSCM, n);
    wr(OFS_CTL2, 8'h08);
    wr(OFS_CTL1, c1);
    wr(OFS_CTL0, c0);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("sck out", pins.sckOut, 1'b1);
    chk("sck oe_n", pins.sckOeN, 1'b0);
    chk("sdo", pins.sdoOut, 1'b0);
    chk("hresp", hresp, 1'b0);
    rd(OFS_PRSM, rdv);
    chk("prescaler mode", rdv, 32'h0);
    rd(OFS_PRSCM, rdv);
    chk("prescaler compare", rdv, 32'h0);
    wr(OFS_PRSCM, 8'hC3);
    rd(OFS_PRSCM, rdv);
    chk("prescaler compare rw", rdv, 32'hC3);
    wr(8'h24, 8'hFF);
    rd(8'h24, rdv);
    chk("unmapped", rdv, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_sck_idle();
    int p, s;
    for (p = 0; p < 2; p++) begin
      for (s = 0; s < 8; s++) begin
        wr(OFS_CTL1, 8'((s << 2) | p));
        @(negedge mclk);
        chk("sck oe_n", pins.sckOeN, s == 7);
        if (s != 7) chk("sck idle", pins.sckOut, p == 0);
        @(posedge mclk);
      end
    end
    $display("test sck idle done");
  endtask
  task automatic t_sdo_idle();
    int t, d, o;
    wr(OFS_TXB, 8'h80);
    for (t = 0; t < 2; t++) begin
      for (d = 0; d < 2; d++) begin
        for (o = 0; o < 2; o++) begin
          wr(OFS_CTL1, 8'(d << 1));
          wr(OFS_CTL0, 8'((t << 1) | (o << 3)));
          @(negedge mclk);
          chk("sdo idle", pins.sdoOut, t && d && !o);
          @(posedge mclk);
        end
      end
    end
    $display("test sdo idle done");
  endtask
  task automatic t_baud();
    int ks[5] = '{0, 1, 2, 3, 0};
    int ns[5] = '{13, 7, 4, 2, 0};
    int i, c;
    logic v;
    for (i = 0; i < 5; i++) begin
      cfg(8'(ks[i]), 8'(ns[i]), 8'h00, 8'h07);
      wr(OFS_TXB, 8'hA5);
      // Look mid-cycle, never in the step of the launching edge
      @(negedge mclk);
      v = pins.sckOut;
      for (c = 0; c < 3000 && pins.sckOut === v; c++) @(negedge mclk);
      v = pins.sckOut;
      for (c = 0; c < 3000 && pins.sckOut === v; c++) @(negedge mclk);
      chk("half period", c, (2 << ks[i]) * (ns[i] == 0 ? 256 : ns[i]));
      wait_irq(i + 1);
    end
    $display("test baud done");
  endtask
  task automatic t_busy(input int dap);
    int base;
    base = irqs;
    cfg(8'h00, 8'd13, 8'(dap << 1), 8'h07);
    wr(OFS_TXB, 8'h5A);
    wr(OFS_TXB, 8'h3C);
    wait_irq(base + 1);
    rd(OFS_STAT, rdv);
    chk("busy after irq", rdv[STAT_BUSY], dap == 1);
    repeat (30) @(posedge mclk);
    rd(OFS_STAT, rdv);
    chk("busy later", rdv[STAT_BUSY], 1'b0);
    repeat (600) @(posedge mclk);
    chk("no second frame", irqs, base + 1);
    rd(OFS_TXB, rdv);
    chk("tx buffer kept", rdv, 32'h5A);
    $display("test busy done");
  endtask
  task automatic t_ext_rx();
    int base;
    base = irqs;
    cfg(8'h00, 8'd13, 8'h1C, 8'h05);
    peerOn <= 1'b1;
    rd(OFS_RXB, rdv);
    rd(OFS_STAT, rdv);
    chk("busy on read", rdv[STAT_BUSY], 1'b1);
    rd(OFS_RXB, rdv);
    peerGo <= 1'b1;
    @(posedge mclk);
    peerGo <= 1'b0;
    wait_irq(base + 1);
    peerOn <= 1'b0;
    repeat (300) @(posedge mclk);
    chk("one rx frame", irqs, base + 1);
    // A read taken while busy must not leave a queued frame behind
    rd(OFS_STAT, rdv);
    chk("busy after rx", rdv[STAT_BUSY], 1'b0);
    rd(OFS_RXB, rdv);
    chk("rx data", rdv, 32'hFF);
    $display("test ext rx done");
  endtask
  // Continuous mode chains a queued word; overrun is read afterwards
  task automatic t_cont();
    int base;
    base = irqs;
    cfg(8'h00, 8'd13, 8'h00, 8'h17);
    wr(OFS_STAT, 8'h02);
    rd(OFS_RXB, rdv);
    wr(OFS_TXB, 8'h11);
    wr(OFS_TXB, 8'h22);
    wait_irq(base + 2);
    rd(OFS_STAT, rdv);
    chk("overrun after chain", rdv[STAT_OVE], 1'b1);
    chk("busy after chain", rdv[STAT_BUSY], 1'b0);
    wr(OFS_STAT, 8'h02);
    rd(OFS_STAT, rdv);
    chk("overrun cleared", rdv[STAT_OVE], 1'b0);
    $display("test cont done");
  endtask
  // ---------------------------------------------------------------
  // Verdict and sequence
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Whole run is near 14k cycles; 50k cycles is far beyond it
  initial begin
    #250000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_sck_idle();
    t_sdo_idle();
    t_baud();
    t_busy(0);
    t_busy(1);
    t_ext_rx();
    t_cont();
    end_of_test();
  end
endmodule // serial_idle_pins_and_baud_generator_test
`default_nettype wire
